// ===== hw/sfc_pkg.sv
// Strobe flash controller package: register map, field layout, modes, states.
// Assumes an 8-bit register port with 16-bit addresses behind the serial control bus.
package sfc_pkg;
  // Register offsets
  localparam logic [15:0] SFC_ADDR_CTRL = 16'h3b00;
  localparam logic [15:0] SFC_ADDR_DMY_H = 16'h3b02;
  localparam logic [15:0] SFC_ADDR_DMY_L = 16'h3b03;
  localparam logic [15:0] SFC_ADDR_TIMING = 16'h3b04;
  localparam logic [15:0] SFC_ADDR_PWIDTH = 16'h3b05;
  // Reset values
  localparam logic [7:0] SFC_RST_CTRL = 8'h00;
  localparam logic [7:0] SFC_RST_DMY = 8'h00;
  localparam logic [7:0] SFC_RST_TIMING = 8'h00;
  localparam logic [7:0] SFC_RST_PWIDTH = 8'h00;
  // Control register fields
  localparam int SFC_CTRL_REQ = 7;
  localparam int SFC_CTRL_POL = 6;
  localparam int SFC_CTRL_XW_HI = 5;
  localparam int SFC_CTRL_XW_LO = 4;
  localparam int SFC_CTRL_MODE_HI = 2;
  // Timing register fields
  localparam int SFC_TIM_START_SEL = 3;
  localparam int SFC_TIM_REPEAT = 2;
  localparam int SFC_TIM_LAT_HI = 1;
  // Pulse width register fields
  localparam int SFC_PW_STEP_HI = 7;
  localparam int SFC_PW_STEP_LO = 2;
  localparam int SFC_PW_GAIN_HI = 1;
  // LED clock-timed base: 128 clocks
  localparam int SFC_PW_BASE_SHIFT = 7;
  // Exposure fraction bits below whole lines
  localparam int SFC_FRAC_BITS = 4;
  // Flash modes
  localparam logic [2:0] SFC_MODE_XENON = 3'h0;
  localparam logic [2:0] SFC_MODE_LED_SINGLE = 3'h1;
  localparam logic [2:0] SFC_MODE_LED_REPEAT = 3'h2;
  localparam logic [2:0] SFC_MODE_LED_HOLD = 3'h3;
  localparam logic [2:0] SFC_MODE_LED_CLOCK = 3'h4;
  // Default frame delays per mode
  localparam logic [2:0] SFC_DLY_XENON = 3'h3;
  localparam logic [2:0] SFC_DLY_LED = 3'h2;
  localparam logic [2:0] SFC_DLY_OTHER = 3'h1;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfc_reg_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PULSE} sfc_state_e;
endpackage : sfc_pkg

// ===== hw/sfc_strobe_flash_controller.sv
// Strobe flash controller: registers, frame delay, pulse timing, strobe pin.
// Assumes frame and row start pulses from the sensor timing generator, one cycle each.
`timescale 1ns/100ps
module sfc_strobe_flash_controller
  import sfc_pkg::*;
#(
  parameter int DMY_W = 16,
  parameter int WIDTH_CNT_W = 17
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // Register port
  input wire sfc_reg_req_s REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  // Sensor timing
  input wire logic FRAME_START_I,
  input wire logic ROW_START_I,
  // Flash and exposure
  output logic STROBE_O,
  output logic [DMY_W+SFC_FRAC_BITS-1:0] EXTRA_LINES_O,
  output logic BUSY_O
);

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] dmy_h_reg, dmy_h_next;
  logic [7:0] dmy_l_reg, dmy_l_next;
  logic [7:0] tim_reg, tim_next;
  logic [7:0] pw_reg, pw_next;
  logic lat_set_reg, lat_set_next;
  sfc_state_e state_reg, state_next;
  logic [2:0] frm_reg, frm_next;
  logic [WIDTH_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic strobe_reg, strobe_next;
  logic [DMY_W+SFC_FRAC_BITS-1:0] extra_reg, extra_next;
  logic busy_reg, busy_next;

  // Register decode
  wire wr_ctrl = REG_REQ_I.wr && (REG_REQ_I.addr == SFC_ADDR_CTRL);
  wire wr_dmy_h = REG_REQ_I.wr && (REG_REQ_I.addr == SFC_ADDR_DMY_H);
  wire wr_dmy_l = REG_REQ_I.wr && (REG_REQ_I.addr == SFC_ADDR_DMY_L);
  wire wr_tim = REG_REQ_I.wr && (REG_REQ_I.addr == SFC_ADDR_TIMING);
  wire wr_pw = REG_REQ_I.wr && (REG_REQ_I.addr == SFC_ADDR_PWIDTH);

  assign ctrl_next = wr_ctrl ? REG_REQ_I.wdata : ctrl_reg;
  assign dmy_h_next = wr_dmy_h ? REG_REQ_I.wdata : dmy_h_reg;
  assign dmy_l_next = wr_dmy_l ? REG_REQ_I.wdata : dmy_l_reg;
  assign tim_next = wr_tim ? REG_REQ_I.wdata : tim_reg;
  assign pw_next = wr_pw ? REG_REQ_I.wdata : pw_reg;
  assign lat_set_next = lat_set_reg | wr_tim;

  wire [7:0] rd_mux =
    (REG_REQ_I.addr == SFC_ADDR_CTRL) ? ctrl_reg :
    (REG_REQ_I.addr == SFC_ADDR_DMY_H) ? dmy_h_reg :
    (REG_REQ_I.addr == SFC_ADDR_DMY_L) ? dmy_l_reg :
    (REG_REQ_I.addr == SFC_ADDR_TIMING) ? tim_reg :
    (REG_REQ_I.addr == SFC_ADDR_PWIDTH) ? pw_reg : 8'h00;
  assign rdata_next = REG_REQ_I.rd ? rd_mux : rdata_reg;

  // Field views
  wire [2:0] mode = ctrl_reg[SFC_CTRL_MODE_HI:0];
  wire req_on = ctrl_reg[SFC_CTRL_REQ];
  wire req_set = wr_ctrl && REG_REQ_I.wdata[SFC_CTRL_REQ] && !req_on;
  wire req_end = wr_ctrl && !REG_REQ_I.wdata[SFC_CTRL_REQ];
  wire is_xenon = (mode == SFC_MODE_XENON);
  wire is_led12 = (mode == SFC_MODE_LED_SINGLE) || (mode == SFC_MODE_LED_REPEAT);
  wire is_hold = (mode == SFC_MODE_LED_HOLD);
  wire is_clock = (mode == SFC_MODE_LED_CLOCK);
  wire mode_ok = is_xenon || is_led12 || is_hold || is_clock;
  wire [2:0] wr_mode = REG_REQ_I.wdata[SFC_CTRL_MODE_HI:0];
  wire wmode_ok = (wr_mode <= SFC_MODE_LED_CLOCK);
  wire next_hold = (ctrl_next[SFC_CTRL_MODE_HI:0] == SFC_MODE_LED_HOLD);
  wire [DMY_W-1:0] dmy = {dmy_h_reg, dmy_l_reg};

  // Frame delay: per-mode default until the latency field is written
  wire [2:0] lat_dly = {1'b0, tim_reg[SFC_TIM_LAT_HI:0]} + 3'h1;
  wire [2:0] mode_dly = is_xenon ? SFC_DLY_XENON :
    is_led12 ? SFC_DLY_LED : SFC_DLY_OTHER;
  wire [2:0] dly = lat_set_reg ? lat_dly : mode_dly;
  wire dly_hit = FRAME_START_I && (frm_reg == dly - 3'h1);

  // Pulse width loads
  wire [WIDTH_CNT_W-1:0] xw_load =
    WIDTH_CNT_W'(ctrl_reg[SFC_CTRL_XW_HI:SFC_CTRL_XW_LO]) + 1'b1;
  wire [WIDTH_CNT_W-1:0] dw_load =
    (dmy == '0) ? WIDTH_CNT_W'(1) : WIDTH_CNT_W'(dmy);
  wire [WIDTH_CNT_W-1:0] cw_load =
    WIDTH_CNT_W'((WIDTH_CNT_W'(pw_reg[SFC_PW_STEP_HI:SFC_PW_STEP_LO]) + 1'b1)
    << (SFC_PW_BASE_SHIFT + pw_reg[SFC_PW_GAIN_HI:0]));
  wire [WIDTH_CNT_W-1:0] w_load = is_xenon ? xw_load : is_clock ? cw_load : dw_load;

  // Width ticks: rows for xenon and LED lines, clocks for clock-timed
  wire tick = is_clock ? 1'b1 : ROW_START_I;
  wire pulse_done = !is_hold && tick && (cnt_reg == WIDTH_CNT_W'(1));
  wire again = req_on && !req_end && (is_led12 || tim_reg[SFC_TIM_REPEAT]);

  // Sequencer
  always_comb begin
    state_next = state_reg;
    frm_next = frm_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_set && wmode_ok) begin
          frm_next = 3'h0;
          if (wr_mode == SFC_MODE_LED_HOLD) begin
            state_next = ST_PULSE;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (dly_hit) begin
          state_next = ST_PULSE;
          cnt_next = w_load;
        end else if (FRAME_START_I) begin
          frm_next = frm_reg + 3'h1;
        end
      end
      ST_PULSE: begin
        if (is_hold) begin
          if (req_end) begin
            state_next = ST_IDLE;
          end
        end else if (pulse_done) begin
          frm_next = 3'h0;
          state_next = again ? ST_WAIT : ST_IDLE;
        end else if (tick) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Output drive
  assign strobe_next = (state_next == ST_PULSE) ^ ctrl_next[SFC_CTRL_POL];
  assign extra_next = (state_next != ST_IDLE && !next_hold) ?
    {dmy, {SFC_FRAC_BITS{1'b0}}} : '0;
  assign busy_next = (state_next != ST_IDLE);

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_reg <= SFC_RST_CTRL;
      dmy_h_reg <= SFC_RST_DMY;
      dmy_l_reg <= SFC_RST_DMY;
      tim_reg <= SFC_RST_TIMING;
      pw_reg <= SFC_RST_PWIDTH;
      lat_set_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      dmy_h_reg <= dmy_h_next;
      dmy_l_reg <= dmy_l_next;
      tim_reg <= tim_next;
      pw_reg <= pw_next;
      lat_set_reg <= lat_set_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
      frm_reg <= 3'h0;
      cnt_reg <= '0;
      strobe_reg <= 1'b0;
      extra_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      frm_reg <= frm_next;
      cnt_reg <= cnt_next;
      strobe_reg <= strobe_next;
      extra_reg <= extra_next;
      busy_reg <= busy_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;
  assign STROBE_O = strobe_reg;
  assign EXTRA_LINES_O = extra_reg;
  assign BUSY_O = busy_reg;

  // Checks
  // Check-side frame count while waiting
  logic [2:0] chk_frm_reg, chk_frm_next;
  assign chk_frm_next = (state_reg != ST_WAIT) ? 3'h0 :
    FRAME_START_I ? chk_frm_reg + 3'h1 : chk_frm_reg;
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      chk_frm_reg <= 3'h0;
    end else begin
      chk_frm_reg <= chk_frm_next;
    end
  end

  a_pol_level:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      STROBE_O == ((state_reg == ST_PULSE) ^ ctrl_reg[SFC_CTRL_POL]))
    else $error("strobe level does not match state and polarity");
  a_idle_inactive:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) |-> (STROBE_O == ctrl_reg[SFC_CTRL_POL]) && !BUSY_O)
    else $error("strobe active while idle");
  a_bad_mode:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) && !mode_ok && !wr_ctrl |=> (state_reg == ST_IDLE))
    else $error("undefined mode left idle");
  a_req_arms:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) && req_set && REG_REQ_I.wdata[SFC_CTRL_MODE_HI:0]
      == SFC_MODE_XENON |=> (state_reg == ST_WAIT) && ctrl_reg[SFC_CTRL_REQ])
    else $error("request did not arm the sequencer");
  a_frame_delay:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_WAIT) && FRAME_START_I && (frm_reg == dly - 3'h1)
      |=> (state_reg == ST_PULSE) && (STROBE_O != ctrl_reg[SFC_CTRL_POL]))
    else $error("strobe missed its frame");
  a_default_delay:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      !lat_set_reg |-> (dly == (is_xenon ? 3'h3 : is_led12 ? 3'h2 : 3'h1)))
    else $error("per-mode frame delay wrong");
  a_width_end:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_PULSE) && !is_hold && tick && (cnt_reg == 1) && !again
      |=> (state_reg == ST_IDLE))
    else $error("pulse did not end on width");
  a_clock_width:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_WAIT) && dly_hit && is_clock && (pw_reg == 8'h00)
      |=> (cnt_reg == 128))
    else $error("clock-timed width load wrong");
  a_led_repeat:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_PULSE) && pulse_done && is_led12 && req_on && !wr_ctrl
      |=> (state_reg == ST_WAIT) && (frm_reg == 3'h0))
    else $error("LED pulse did not repeat");
  a_hold_lines:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_PULSE) && is_hold && !wr_ctrl
      |=> (state_reg == ST_PULSE) && (EXTRA_LINES_O == '0))
    else $error("hold mode dropped strobe or added lines");
  a_mode_refused:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) && wr_ctrl && !wmode_ok |=> (state_reg == ST_IDLE))
    else $error("undefined mode started a strobe");
  a_hold_start:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) && req_set && (wr_mode == SFC_MODE_LED_HOLD)
      |=> (state_reg == ST_PULSE) && (STROBE_O != ctrl_reg[SFC_CTRL_POL]))
    else $error("hold request did not raise the strobe");
  a_hold_end:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_PULSE) && is_hold && req_end |=> (state_reg == ST_IDLE))
    else $error("hold strobe did not end on request");
  a_busy_match:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      BUSY_O == (state_reg != ST_IDLE))
    else $error("busy flag does not match sequencer");
  a_extra_level:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg != ST_IDLE) && !is_hold && $stable(dmy) |-> (EXTRA_LINES_O == {dmy, 4'h0}))
    else $error("extra lines do not match dummy count");
  a_extra_idle:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_IDLE) |-> (EXTRA_LINES_O == '0))
    else $error("extra lines added while idle");
  a_frac_zero:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      EXTRA_LINES_O[SFC_FRAC_BITS-1:0] == '0)
    else $error("fraction bits of extra lines not zero");
  a_xenon_rows:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_PULSE) && is_xenon && ROW_START_I && (cnt_reg > 1) |=> (state_reg == ST_PULSE))
    else $error("xenon pulse ended early");
  a_no_early:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      (state_reg == ST_WAIT) && FRAME_START_I && (chk_frm_reg + 3'h1 < dly)
      |=> (state_reg == ST_WAIT))
    else $error("strobe fired before its frame");
  a_lat_override:
    assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
      lat_set_reg && (tim_reg[SFC_TIM_LAT_HI:0] == 2'b11) |-> (dly == 3'h4))
    else $error("latency field not applied");

endmodule : sfc_strobe_flash_controller

// ===== testbench/sfc_flash_driver_model.sv
// Flash driver model: counts triggers and measures pulse width in clocks.
// Assumes the bench tells it which strobe level is the active one.
`timescale 1ns/100ps
module sfc_flash_driver_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // Strobe pin and its polarity
  input wire logic strobe_i,
  input wire logic inv_i,
  // Observations
  output int trig_cnt_o,
  output int width_o
);
  logic act;
  logic act_d;
  int run;
  assign act = strobe_i ^ inv_i;
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      act_d <= 1'b0;
      trig_cnt_o <= 0;
      width_o <= 0;
      run <= 0;
    end else begin
      act_d <= act;
      if (act && !act_d) trig_cnt_o <= trig_cnt_o + 1;
      if (act) run <= run + 1;
      else if (act_d) begin
        width_o <= run;
        run <= 0;
      end
    end
  end
endmodule : sfc_flash_driver_model

// ===== testbench/strobe_flash_controller_bench.sv
// Bench for the strobe flash controller: register tasks and strobe sequences.
// Assumes the design package and the flash driver model are compiled first.
`timescale 1ns/100ps
module strobe_flash_controller_bench;
  import sfc_pkg::*;
  logic REF_CLK_I;
  logic RESETN_I;
  sfc_reg_req_s REG_REQ_I;
  logic [7:0] REG_RDATA_O;
  logic FRAME_START_I;
  logic ROW_START_I;
  logic STROBE_O;
  logic [19:0] EXTRA_LINES_O;
  logic BUSY_O;
  logic inv;
  int trig;
  int width;
  int num_errors = 0;
  int n_tests = 0;

  sfc_strobe_flash_controller dut_u (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I),
    .REG_REQ_I(REG_REQ_I), .REG_RDATA_O(REG_RDATA_O), .FRAME_START_I(FRAME_START_I),
    .ROW_START_I(ROW_START_I), .STROBE_O(STROBE_O), .EXTRA_LINES_O(EXTRA_LINES_O),
    .BUSY_O(BUSY_O));
  sfc_flash_driver_model flash_u (.clk_i(REF_CLK_I), .rst_ni(RESETN_I),
    .strobe_i(STROBE_O), .inv_i(inv), .trig_cnt_o(trig), .width_o(width));

  initial begin
    REF_CLK_I = 1'b0;
    forever #2 REF_CLK_I = ~REF_CLK_I;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge REF_CLK_I) REG_REQ_I = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge REF_CLK_I) REG_REQ_I = '0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge REF_CLK_I) REG_REQ_I = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge REF_CLK_I) REG_REQ_I = '0;
    @(negedge REF_CLK_I) check(REG_RDATA_O, exp);
  endtask : rd

  // Sensor timing pulses, one cycle each
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge REF_CLK_I) FRAME_START_I = 1'b1;
      @(negedge REF_CLK_I) FRAME_START_I = 1'b0;
      repeat (6) @(negedge REF_CLK_I);
    end
  endtask : frames

  task automatic rows(input int n);
    repeat (n) begin
      @(negedge REF_CLK_I) ROW_START_I = 1'b1;
      @(negedge REF_CLK_I) ROW_START_I = 1'b0;
      repeat (4) @(negedge REF_CLK_I);
    end
  endtask : rows

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  initial begin
    logic [15:0] regs [5];
    regs = '{SFC_ADDR_CTRL, SFC_ADDR_DMY_H, SFC_ADDR_DMY_L, SFC_ADDR_TIMING, SFC_ADDR_PWIDTH};
    REG_REQ_I = '0;
    FRAME_START_I = 1'b0;
    ROW_START_I = 1'b0;
    RESETN_I = 1'b0;
    inv = 1'b0;
    repeat (2) @(negedge REF_CLK_I);
    RESETN_I = 1'b1;
    check(STROBE_O, 1'b0);
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(16'h3b01, 8'hff);
    rd(16'h3b01, 8'h00);
    // Xenon, two rows wide
    wr(SFC_ADDR_CTRL, 8'h90);
    check(BUSY_O, 1'b1);
    frames(2);
    check(STROBE_O, 1'b0);
    frames(1);
    check(STROBE_O, 1'b1);
    rows(1);
    check(STROBE_O, 1'b1);
    rows(1);
    check(STROBE_O, 1'b0);
    wr(SFC_ADDR_CTRL, 8'h10);
    check(trig, 1);
    check(BUSY_O, 1'b0);
    // LED single pulse, end already given
    wr(SFC_ADDR_DMY_L, 8'h02);
    wr(SFC_ADDR_CTRL, 8'h81);
    wr(SFC_ADDR_CTRL, 8'h01);
    check(EXTRA_LINES_O, 20'h00020);
    frames(1);
    check(STROBE_O, 1'b0);
    frames(1);
    check(STROBE_O, 1'b1);
    rows(2);
    check(STROBE_O, 1'b0);
    frames(3);
    check(trig, 2);
    check(BUSY_O, 1'b0);
    // LED repeating, ended while waiting: the armed pulse still fires once more
    wr(SFC_ADDR_CTRL, 8'h82);
    repeat (2) begin
      frames(2);
      rows(2);
    end
    wr(SFC_ADDR_CTRL, 8'h02);
    check(trig, 4);
    frames(2);
    rows(2);
    check(trig, 5);
    check(BUSY_O, 1'b0);
    // Latency override and clock-timed width
    wr(SFC_ADDR_TIMING, 8'h0f);
    rd(SFC_ADDR_TIMING, 8'h0f);
    wr(SFC_ADDR_TIMING, 8'h01);
    wr(SFC_ADDR_PWIDTH, 8'h05);
    rd(SFC_ADDR_PWIDTH, 8'h05);
    wr(SFC_ADDR_CTRL, 8'h84);
    wr(SFC_ADDR_CTRL, 8'h04);
    frames(1);
    check(STROBE_O, 1'b0);
    frames(1);
    check(STROBE_O, 1'b1);
    repeat (600) @(negedge REF_CLK_I);
    check(width, 512);
    wr(SFC_ADDR_PWIDTH, 8'h00);
    wr(SFC_ADDR_CTRL, 8'h84);
    wr(SFC_ADDR_CTRL, 8'h04);
    frames(2);
    check(STROBE_O, 1'b1);
    repeat (200) @(negedge REF_CLK_I);
    check(width, 128);
    // Xenon repeat enable, ended during the second pulse
    wr(SFC_ADDR_TIMING, 8'h05);
    wr(SFC_ADDR_CTRL, 8'h80);
    frames(2);
    rows(1);
    check(BUSY_O, 1'b1);
    frames(2);
    check(STROBE_O, 1'b1);
    wr(SFC_ADDR_CTRL, 8'h00);
    rows(1);
    check(BUSY_O, 1'b0);
    // Hold mode with inverted polarity
    wr(SFC_ADDR_CTRL, 8'h40);
    check(STROBE_O, 1'b1);
    inv = 1'b1;
    wr(SFC_ADDR_CTRL, 8'hc3);
    repeat (2) @(negedge REF_CLK_I);
    check(STROBE_O, 1'b0);
    check(EXTRA_LINES_O, 20'h00000);
    frames(3);
    check(STROBE_O, 1'b0);
    wr(SFC_ADDR_CTRL, 8'h43);
    repeat (2) @(negedge REF_CLK_I);
    check(STROBE_O, 1'b1);
    check(trig, 10);
    end_sim();
  end
endmodule : strobe_flash_controller_bench
